// ==== core/ssfs_top.sv ====
/*
  Softstarter fault supervisor: start/stop sequencing, fault latch, relays, LED code.
  Assumes detector and contact pins are asynchronous; nv_mode_in and decel_time_in
  come from logic on mclk_in; the ramp itself is done by external analog control.
*/
// Summary of operation
// (R1) Closing the start/stop contact begins a soft start.
// (R2) Opening the contact begins a soft stop; mains must stay applied.
// (R3) Soft stop length follows the deceleration time setting.
// (R4) Any fault opens the fault relay and starts the LED flash code; the code ignores faults in programming mode.
// (R5) Codes 1 to 8 flash as many times as the code, then pause.
// (R6) Code 9 flashes ten times per group.
// (R7) Code 10 flashes eleven times per group.
// (R8) Code 1 is supply undervoltage, code 2 heat-sink overtemperature.
// (R9) Motor thermistor overtemperature also reports code 2 where fitted.
// (R10) Code 3 is current control timeout.
// (R11) Acceleration past the internal time limit aborts the start into fault.
// (R12) Code 4 is a zero-crossing error.
// (R13) Codes 5, 6, 7 are phase failures in phases 1, 2, 3.
// (R14) Code 8 is a firing error in phase 1.
// (R15) Default mode clears a fault only by a power cycle.
// (R16) Restart mode clears a fault on contact open then close.
// (R17) Programming wiring at power-up: slow blink power mode, fast blink restart mode.
// (R18) In programming each open then close toggles the mode and blink rate.
// (R19) The selected mode is written to non-volatile storage.
// (R20) Bypass relay energizes when the start ramp completes.
// (R21) Fault, open relay and removed drive hold until the mode's reset event.
// (R22) Flash, pause and blink times are design parameters.
`timescale 1ns/1ns
`default_nettype none
`include "ssfs_defines.svh"
module ssfs_top #(
  parameter bit HAS_MOTOR_PTC = 1'b1,
  parameter int unsigned FLASH_CYC = `SSFS_FLASH_MS * `SSFS_CLK_KHZ, // [R22]
  parameter int unsigned PAUSE_CYC = `SSFS_PAUSE_MS * `SSFS_CLK_KHZ, // [R22]
  parameter int unsigned SLOW_CYC = `SSFS_SLOW_MS * `SSFS_CLK_KHZ, // [R22]
  parameter int unsigned FAST_CYC = `SSFS_FAST_MS * `SSFS_CLK_KHZ, // [R22]
  parameter int unsigned ACCEL_CYC = `SSFS_ACCEL_LIMIT_MS * `SSFS_CLK_KHZ,
  parameter int unsigned DECEL_STEP_CYC = `SSFS_DECEL_STEP_MS * `SSFS_CLK_KHZ
) (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic start_stop_contact_in,
  input wire logic prog_wiring_in,
  input wire logic undervolt_in,
  input wire logic heatsink_hot_in,
  input wire logic motor_ptc_hot_in,
  input wire logic zero_cross_err_in,
  input wire logic phase1_fail_in,
  input wire logic phase2_fail_in,
  input wire logic phase3_fail_in,
  input wire logic fire1_err_in,
  input wire logic fire3_err_in,
  input wire logic elec_fail_in,
  input wire logic ramp_done_in,
  input wire logic [7:0] decel_time_in,
  input wire logic nv_mode_in,
  output logic motor_drive_out,
  output logic ramp_up_out,
  output logic ramp_down_out,
  output logic fault_indicator_relay_out,
  output logic bypass_indicator_relay_out,
  output logic led_yellow_out,
  output logic [3:0] fault_code_out,
  output logic nv_write_out,
  output logic nv_mode_out
);
  localparam int NS = `SSFS_NDET + 3;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  ssfs_pkg::ssfs_state_t state;
  ssfs_pkg::ssfs_state_t next_state;
  logic [31:0] tmr;
  logic [31:0] next_tmr;
  logic [1:0] init_cnt;
  logic mode;
  logic seen_open;
  logic [31:0] led_tmr;
  logic [31:0] next_led_tmr;
  logic [3:0] flash_cnt;
  logic [3:0] next_flash_cnt;
  logic led_pause;
  logic next_led_pause;
  logic next_led;

  // Two-stage synchronisers for the detector, contact, programming wiring and ramp done pins
  wire [NS-1:0] pins = {ramp_done_in, prog_wiring_in, start_stop_contact_in,
    elec_fail_in, fire3_err_in, fire1_err_in, phase3_fail_in, phase2_fail_in,
    phase1_fail_in, zero_cross_err_in, motor_ptc_hot_in, heatsink_hot_in, undervolt_in};
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
    end
  end
  wire [`SSFS_NDET-1:0] det = sync2[`SSFS_NDET-1:0];
  wire closed = sync2[`SSFS_NDET];
  wire prog_s = sync2[`SSFS_NDET+1];
  wire ramp_done_s = sync2[`SSFS_NDET+2];
  wire ptc_hot = det[2] & HAS_MOTOR_PTC; // [R9]

  // Fault detection and priority encoding
  wire in_op = (state == ssfs_pkg::ssfs_idle) || (state == ssfs_pkg::ssfs_start) ||
    (state == ssfs_pkg::ssfs_run) || (state == ssfs_pkg::ssfs_stop);
  wire accel_timeout = (state == ssfs_pkg::ssfs_start) && !ramp_done_s &&
    (tmr == 32'(ACCEL_CYC - 1)); // [R11]
  wire flt_any = (|det[1:0]) | ptc_hot | (|det[9:3]) | accel_timeout;
  wire [3:0] det_code =
    det[0] ? `SSFS_CODE_UNDERVOLT : // [R8]
    (det[1] | ptc_hot) ? `SSFS_CODE_THERMAL : // [R8] [R9]
    accel_timeout ? `SSFS_CODE_TIMEOUT : // [R10]
    det[3] ? `SSFS_CODE_ZERO_CROSS : // [R12]
    det[4] ? `SSFS_CODE_PHASE1 : // [R13]
    det[5] ? `SSFS_CODE_PHASE2 : // [R13]
    det[6] ? `SSFS_CODE_PHASE3 : // [R13]
    det[7] ? `SSFS_CODE_FIRE1 : // [R14]
    det[8] ? `SSFS_CODE_FIRE3 :
    det[9] ? `SSFS_CODE_ELEC : `SSFS_CODE_NONE;
  wire [3:0] flash_target =
    (fault_code_out == `SSFS_CODE_FIRE3) ? `SSFS_FLASH_FIRE3 : // [R6]
    (fault_code_out == `SSFS_CODE_ELEC) ? `SSFS_FLASH_ELEC : fault_code_out; // [R5] [R7]

  // Sequencing
  wire stop_done = (tmr == 32'h0);
  wire reclose = seen_open && closed;
  wire restart_clear = (mode == `SSFS_MODE_RESTART) && reclose && !flt_any; // [R16] [R21]
  always_comb begin
    next_state = state;
    unique case (state)
      ssfs_pkg::ssfs_init:
        if (init_cnt == `SSFS_INIT_WAIT) begin
          next_state = prog_s ? ssfs_pkg::ssfs_prog : ssfs_pkg::ssfs_idle; // [R17]
        end
      ssfs_pkg::ssfs_idle:
        if (flt_any) next_state = ssfs_pkg::ssfs_fault; // [R4]
        else if (closed) next_state = ssfs_pkg::ssfs_start; // [R1]
      ssfs_pkg::ssfs_start:
        if (flt_any) next_state = ssfs_pkg::ssfs_fault; // [R4] [R11]
        else if (!closed) next_state = ssfs_pkg::ssfs_stop; // [R2]
        else if (ramp_done_s) next_state = ssfs_pkg::ssfs_run; // [R20]
      ssfs_pkg::ssfs_run:
        if (flt_any) next_state = ssfs_pkg::ssfs_fault; // [R4]
        else if (!closed) next_state = ssfs_pkg::ssfs_stop; // [R2]
      ssfs_pkg::ssfs_stop:
        if (flt_any) next_state = ssfs_pkg::ssfs_fault; // [R2] [R4]
        else if (closed) next_state = ssfs_pkg::ssfs_start; // [R1]
        else if (stop_done) next_state = ssfs_pkg::ssfs_idle; // [R3]
      ssfs_pkg::ssfs_fault:
        if (restart_clear) next_state = ssfs_pkg::ssfs_idle; // [R15] [R16] [R21]
      ssfs_pkg::ssfs_prog:
        next_state = ssfs_pkg::ssfs_prog;
      default:
        next_state = ssfs_pkg::ssfs_init;
    endcase
  end

  wire enter_stop = (state != ssfs_pkg::ssfs_stop) && (next_state == ssfs_pkg::ssfs_stop);
  wire [31:0] stop_load = 32'({24'h0, decel_time_in} * DECEL_STEP_CYC); // [R3]
  assign next_tmr = enter_stop ? stop_load :
    (next_state != state) ? 32'h0 :
    (state == ssfs_pkg::ssfs_start) ? tmr + 32'h1 :
    ((state == ssfs_pkg::ssfs_stop) && !stop_done) ? tmr - 32'h1 : tmr;

  wire next_drive = (next_state == ssfs_pkg::ssfs_start) ||
    (next_state == ssfs_pkg::ssfs_run) || (next_state == ssfs_pkg::ssfs_stop); // [R21]
  wire entering_fault = (state != ssfs_pkg::ssfs_fault) &&
    (next_state == ssfs_pkg::ssfs_fault);
  wire prog_toggle = (state == ssfs_pkg::ssfs_prog) && reclose; // [R18]
  wire watch_open = (state == ssfs_pkg::ssfs_fault) || (state == ssfs_pkg::ssfs_prog);

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= ssfs_pkg::ssfs_init;
      tmr <= 32'h0;
      init_cnt <= 2'h0;
    end else begin
      state <= next_state;
      tmr <= next_tmr;
      init_cnt <= (init_cnt == `SSFS_INIT_WAIT) ? init_cnt : init_cnt + 2'h1;
    end
  end

  // Reset mode, open/close tracking, storage write
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode <= `SSFS_MODE_POWER;
      seen_open <= 1'b0;
      nv_write_out <= 1'b0;
      nv_mode_out <= `SSFS_MODE_POWER;
    end else begin
      if ((state == ssfs_pkg::ssfs_init) && (init_cnt == `SSFS_INIT_WAIT)) begin
        mode <= nv_mode_in; // [R19]
        nv_mode_out <= nv_mode_in;
      end else if (prog_toggle) begin
        mode <= ~mode; // [R18]
        nv_mode_out <= ~mode; // [R19]
      end
      nv_write_out <= prog_toggle; // [R19]
      seen_open <= watch_open && !reclose && (seen_open || !closed);
    end
  end

  // Relay, drive and code outputs
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      motor_drive_out <= 1'b0;
      ramp_up_out <= 1'b0;
      ramp_down_out <= 1'b0;
      fault_indicator_relay_out <= 1'b0;
      bypass_indicator_relay_out <= 1'b0;
      fault_code_out <= `SSFS_CODE_NONE;
    end else begin
      motor_drive_out <= next_drive; // [R21]
      ramp_up_out <= (next_state == ssfs_pkg::ssfs_start); // [R1]
      ramp_down_out <= (next_state == ssfs_pkg::ssfs_stop); // [R2]
      fault_indicator_relay_out <= (next_state != ssfs_pkg::ssfs_fault); // [R4] [R21]
      bypass_indicator_relay_out <= (next_state == ssfs_pkg::ssfs_run); // [R20]
      if (entering_fault) fault_code_out <= det_code; // [R4]
      else if (next_state != ssfs_pkg::ssfs_fault) fault_code_out <= `SSFS_CODE_NONE;
    end
  end

  // LED flasher: fault code groups or programming blink
  always_comb begin
    next_led = 1'b0;
    next_led_tmr = 32'h0;
    next_flash_cnt = 4'h0;
    next_led_pause = 1'b0;
    if (state == ssfs_pkg::ssfs_fault) begin
      next_led = led_yellow_out;
      next_flash_cnt = flash_cnt;
      next_led_pause = led_pause;
      if (led_tmr != 32'h0) begin
        next_led_tmr = led_tmr - 32'h1;
      end else if (led_yellow_out) begin
        next_led = 1'b0; // [R5]
        next_led_pause = (flash_cnt == flash_target - 4'h1);
        next_led_tmr = next_led_pause ? 32'(PAUSE_CYC - 1) : 32'(FLASH_CYC - 1);
        next_flash_cnt = next_led_pause ? 4'h0 : flash_cnt + 4'h1;
      end else begin
        next_led = 1'b1; // [R4]
        next_led_pause = 1'b0;
        next_led_tmr = 32'(FLASH_CYC - 1);
      end
    end else if (state == ssfs_pkg::ssfs_prog) begin
      next_led = led_yellow_out;
      if (led_tmr != 32'h0) begin
        next_led_tmr = led_tmr - 32'h1;
      end else begin
        next_led = ~led_yellow_out; // [R17] [R18]
        next_led_tmr = (mode == `SSFS_MODE_RESTART) ? 32'(FAST_CYC - 1) :
          32'(SLOW_CYC - 1);
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      led_yellow_out <= 1'b0;
      led_tmr <= 32'h0;
      flash_cnt <= 4'h0;
      led_pause <= 1'b0;
    end else begin
      led_yellow_out <= next_led;
      led_tmr <= next_led_tmr;
      flash_cnt <= next_flash_cnt;
      led_pause <= next_led_pause;
    end
  end

  // Checks
  a_start_on_close: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R1]
    (state == ssfs_pkg::ssfs_idle) && closed && !flt_any |=> ramp_up_out && motor_drive_out)
    else $error("start not begun on contact close");
  a_stop_on_open: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R2]
    (state == ssfs_pkg::ssfs_run) && !closed && !flt_any |=> ramp_down_out && motor_drive_out)
    else $error("stop not begun on contact open");
  a_stop_length: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R3]
    enter_stop && !closed |=> (tmr == $past(stop_load)))
    else $error("stop duration not loaded from setting");
  a_fault_relay_open: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R4]
    entering_fault |=> !fault_indicator_relay_out && !motor_drive_out ##1 led_yellow_out)
    else $error("fault did not open relay or start flashing");
  a_flash_count: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R5]
    (state == ssfs_pkg::ssfs_fault) |-> (flash_cnt < flash_target))
    else $error("flash count exceeds group size");
  a_code_undervolt: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R8]
    entering_fault && det[0] |=> (fault_code_out == `SSFS_CODE_UNDERVOLT))
    else $error("undervoltage not reported as code 1");
  a_accel_timeout: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R11]
    accel_timeout && !(|det) |=> (state == ssfs_pkg::ssfs_fault) &&
    (fault_code_out == `SSFS_CODE_TIMEOUT))
    else $error("acceleration timeout not latched as code 3");
  a_power_hold: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R15]
    (state == ssfs_pkg::ssfs_fault) && (mode == `SSFS_MODE_POWER) |=>
    (state == ssfs_pkg::ssfs_fault) && !fault_indicator_relay_out)
    else $error("fault cleared without power cycle");
  a_restart_clear: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R16]
    (state == ssfs_pkg::ssfs_fault) && restart_clear |=> fault_indicator_relay_out)
    else $error("restart did not clear fault");
  a_prog_toggle: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R18]
    prog_toggle |=> nv_write_out && (nv_mode_out != $past(mode)))
    else $error("programming toggle not stored");
  a_bypass_on: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // [R20]
    (state == ssfs_pkg::ssfs_start) && ramp_done_s && closed && !flt_any |=>
    bypass_indicator_relay_out)
    else $error("bypass relay not energized after ramp");
  c_full_start: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    (state == ssfs_pkg::ssfs_start) ##1 (state == ssfs_pkg::ssfs_run));
  c_fault_pause: cover property (@(posedge mclk_in) disable iff (!rst_b_in)
    (state == ssfs_pkg::ssfs_fault) && led_pause);
  c_prog_toggle: cover property (@(posedge mclk_in) disable iff (!rst_b_in) prog_toggle);
endmodule // ssfs_top
`default_nettype wire

// ==== core/ssfs_defines.svh ====
/*
  Constants of the softstarter fault supervisor: clock rate, times, fault codes.
  Assumes it is included by bare name from core/ files.
*/
`ifndef SSFS_DEFINES_SVH
`define SSFS_DEFINES_SVH
`define SSFS_CLK_KHZ 100000
`define SSFS_FLASH_MS 250
`define SSFS_PAUSE_MS 1500
`define SSFS_SLOW_MS 500
`define SSFS_FAST_MS 100
`define SSFS_ACCEL_LIMIT_MS 20000
`define SSFS_DECEL_STEP_MS 50
`define SSFS_INIT_WAIT 2'h3
`define SSFS_MODE_POWER 1'b0
`define SSFS_MODE_RESTART 1'b1
`define SSFS_CODE_NONE 4'h0
`define SSFS_CODE_UNDERVOLT 4'h1
`define SSFS_CODE_THERMAL 4'h2
`define SSFS_CODE_TIMEOUT 4'h3
`define SSFS_CODE_ZERO_CROSS 4'h4
`define SSFS_CODE_PHASE1 4'h5
`define SSFS_CODE_PHASE2 4'h6
`define SSFS_CODE_PHASE3 4'h7
`define SSFS_CODE_FIRE1 4'h8
`define SSFS_CODE_FIRE3 4'h9
`define SSFS_CODE_ELEC 4'hA
`define SSFS_FLASH_FIRE3 4'hA
`define SSFS_FLASH_ELEC 4'hB
`define SSFS_NDET 10
`endif

// ==== core/ssfs_pkg.sv ====
/*
  Types of the softstarter fault supervisor.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package ssfs_pkg;
  typedef enum logic [2:0] {
    ssfs_init, ssfs_idle, ssfs_start, ssfs_run, ssfs_stop, ssfs_fault, ssfs_prog
  } ssfs_state_t;
  typedef logic [3:0] ssfs_code_t;
endpackage
`default_nettype wire

// ==== verif/ssfs_motor_model.sv ====
/*
  Motor and ramp model beside the fault supervisor: reports ramp done.
  Assumes the same clock and reset as the supervisor; ramp_len_in of 0 stalls.
*/
`timescale 1ns/1ns
`default_nettype none
module ssfs_motor_model (
  input wire logic mclk_in,
  input wire logic rst_b_in,
  input wire logic ramp_up_in,
  input wire logic drive_in,
  input wire logic [7:0] ramp_len_in,
  output logic ramp_done_out
);
  logic [7:0] cnt;
  // Ramp completes ramp_len_in cycles into the soft start, never if stalled
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt <= 8'h00;
    end else if (!drive_in) begin
      cnt <= 8'h00;
    end else if (ramp_up_in && cnt != 8'hFF) begin
      cnt <= cnt + 8'h01;
    end
  end
  assign ramp_done_out = (ramp_len_in != 8'h00) && (cnt >= ramp_len_in);
endmodule // ssfs_motor_model
`default_nettype wire

// ==== verif/tb_top.sv ====
/*
  Self-checking bench of the fault supervisor: start, stop, fault codes, reset modes.
  Assumes small timing parameters and a motor model answering ramp done.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int unsigned FL = 4;
  localparam int unsigned SL = 8;
  localparam int unsigned FA = 2;
  localparam int unsigned AC = 50;
  logic mclk_in = 1'b0;
  logic rst_b = 1'b0, contact = 1'b0, prog = 1'b0, nv_mode = 1'b0, done;
  logic [9:0] det = 10'h000;
  logic [7:0] decel = 8'h04, ramp_len = 8'h05;
  logic drive, rup, rdown, relay, bypass, led, nv_wr, nv_mode_q;
  logic [3:0] code;
  int num_errors = 0;
  int checks_done = 0;
  int n, d;
  initial forever #5 mclk_in = ~mclk_in;
  ssfs_top #(.FLASH_CYC(FL), .PAUSE_CYC(16), .SLOW_CYC(SL), .FAST_CYC(FA), .ACCEL_CYC(AC),
    .DECEL_STEP_CYC(2)) dut_u (.mclk_in(mclk_in), .rst_b_in(rst_b),
    .start_stop_contact_in(contact), .prog_wiring_in(prog), .undervolt_in(det[0]),
    .heatsink_hot_in(det[1]), .motor_ptc_hot_in(det[2]), .zero_cross_err_in(det[3]),
    .phase1_fail_in(det[4]), .phase2_fail_in(det[5]), .phase3_fail_in(det[6]),
    .fire1_err_in(det[7]), .fire3_err_in(det[8]), .elec_fail_in(det[9]),
    .ramp_done_in(done), .decel_time_in(decel), .nv_mode_in(nv_mode),
    .motor_drive_out(drive), .ramp_up_out(rup), .ramp_down_out(rdown),
    .fault_indicator_relay_out(relay), .bypass_indicator_relay_out(bypass),
    .led_yellow_out(led), .fault_code_out(code), .nv_write_out(nv_wr),
    .nv_mode_out(nv_mode_q));
  ssfs_motor_model motor_u (.mclk_in(mclk_in), .rst_b_in(rst_b), .ramp_up_in(rup),
    .drive_in(drive), .ramp_len_in(ramp_len), .ramp_done_out(done));
  task automatic cyc(input int k);
    repeat (k) @(negedge mclk_in);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic restart(input logic p, input logic m);
    rst_b = 1'b0;
    det = 10'h000;
    prog = p;
    nv_mode = m;
    cyc(3);
    rst_b = 1'b1;
    cyc(8);
  endtask
  function automatic logic [3:0] exp_code(input int i);
    logic [3:0] t[10] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA};
    return t[i];
  endfunction
  function automatic int exp_flashes(input logic [3:0] c);
    return (c == 4'h9) ? 10 : (c == 4'hA) ? 11 : int'(c);
  endfunction
  // Skip to a pause, then count rising edges of one flash group
  task automatic count_group(output int k);
    int low, guard;
    logic prev;
    k = 0;
    low = 0;
    guard = 0;
    prev = led;
    while (low <= FL + 2 && guard < 500) begin
      cyc(1);
      guard++;
      low = led ? 0 : low + 1;
    end
    low = 0;
    while ((k == 0 || low <= FL + 2) && guard < 1000) begin
      prev = led;
      cyc(1);
      guard++;
      low = led ? 0 : low + 1;
      if (led && !prev) k++;
    end
  endtask
  // Cycles between two successive changes of the LED
  task automatic led_period(output int k);
    logic s;
    int g;
    s = led;
    g = 0;
    while (led === s && g < 100) begin
      cyc(1);
      g++;
    end
    s = led;
    k = 0;
    while (led === s && k < 100) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic open_close(input logic want_nv);
    int pulses;
    pulses = 0;
    contact = 1'b0;
    cyc(5);
    contact = 1'b1;
    repeat (8) begin
      cyc(1);
      pulses += int'(nv_wr === 1'b1);
    end
    check("nv_write_pulses", pulses, want_nv);
  endtask
  initial begin
    void'($urandom(32'h3557E7A2));
    cyc(3);
    rst_b = 1'b1;
    cyc(8);
    check("relay_idle", relay, 1'b1);
    // Start, ramp, bypass, then soft stop of random length
    repeat (3) begin
      d = 2 + ($urandom % 20);
      decel = 8'(d);
      ramp_len = 8'(1 + ($urandom % 30));
      contact = 1'b1;
      cyc(4);
      check("ramp_up", {drive, rup}, 2'h3);
      cyc(int'(ramp_len) + 6);
      check("bypass", {bypass, rup, relay}, 3'h5);
      contact = 1'b0;
      cyc(4);
      check("ramp_down", {rdown, bypass, drive}, 3'h5);
      cyc(2 * d - 3);
      check("stop_held", rdown, 1'b1);
      cyc(3);
      check("stopped", {drive, rdown}, 2'h0);
    end
    // Each detector in turn, in power-cycle mode, with a random start state
    for (int i = 0; i < 10; i++) begin
      restart(1'b0, 1'b0);
      contact = 1'($urandom);
      cyc(int'($urandom % 8));
      det[i] = 1'b1;
      cyc(5);
      check("fault_code", code, exp_code(i));
      check("fault_relay_drive", {relay, drive}, 2'h0);
      count_group(n);
      check("flashes", n, exp_flashes(exp_code(i)));
      det = 10'h000;
      open_close(1'b0);
      cyc(6);
      check("power_mode_held", {code, drive}, {exp_code(i), 1'b0});
    end
    // Stalled ramp times out into code 3
    restart(1'b0, 1'b0);
    ramp_len = 8'h00;
    contact = 1'b1;
    cyc(AC + 10);
    check("timeout_code", {code, drive, relay}, {4'h3, 2'h0});
    // Restart mode clears on open then close once detectors are clear
    restart(1'b0, 1'b1);
    ramp_len = 8'h05;
    contact = 1'b1;
    det[4] = 1'b1;
    cyc(8);
    check("restart_fault", code, 4'h5);
    det = 10'h000;
    open_close(1'b0);
    cyc(4);
    check("restart_cleared", {code, relay, drive}, {4'h0, 2'h3});
    // Programming: slow blink, toggle to fast, toggle back
    contact = 1'b1;
    restart(1'b1, 1'b0);
    led_period(n);
    check("slow_blink", n, SL);
    open_close(1'b1);
    check("nv_mode_fast", nv_mode_q, 1'b1);
    led_period(n);
    check("fast_blink", n, FA);
    open_close(1'b1);
    check("nv_mode_slow", nv_mode_q, 1'b0);
    det[0] = 1'b1;
    cyc(6);
    check("prog_ignores_fault", code, 4'h0);
    // Programming wiring with restart mode stored: fast blink from power-up
    restart(1'b1, 1'b1);
    led_period(n);
    check("fast_at_power_up", n, FA);
    check("nv_mode_kept", nv_mode_q, 1'b1);
    conclude();
  end
  initial begin
    cyc(40000);
    num_errors++;
    conclude();
  end
endmodule // tb_top
`default_nettype wire
